// [hw/cdpm_map.svh]
// Register offsets, field positions, reset values and timing counts of the port mux
`ifndef CDPM_MAP_SVH
`define CDPM_MAP_SVH

// Register offsets (byte addresses)
`define CDPM_REG_CFG 4'h0
`define CDPM_REG_NX64 4'h4
`define CDPM_REG_STATUS 4'h8

// Configuration field positions
`define CDPM_CFG_MODE 1:0
`define CDPM_CFG_BYPASS 2
`define CDPM_CFG_FMT 4:3
`define CDPM_CFG_VARIANT 6:5
`define CDPM_CFG_DUAL 7
`define CDPM_CFG_ADDR_A 12:8
`define CDPM_CFG_ADDR_B 17:13
`define CDPM_CFG_W 18
`define CDPM_CFG_RESET 18'h00000
`define CDPM_NX64_RESET 5'h01

// Frame lengths in bits
`define CDPM_E1_BITS 9'h100
`define CDPM_T1_BITS 9'h0C1

// Last byte index of a 53-octet cell
`define CDPM_CELL_LAST 6'h34

// Side pin indices
`define CDPM_SIDE_TXCK 0
`define CDPM_SIDE_RXCK 1
`define CDPM_SIDE_RXSTART 2
`define CDPM_SIDE_RXCLAV 3
`define CDPM_SIDE_TXCLAV 4

// Timing
`define CDPM_CLK_NS 4
`define CDPM_BIT_MIN_NS 50
`define CDPM_BIT_MIN_CYC ((`CDPM_BIT_MIN_NS + `CDPM_CLK_NS - 1) / `CDPM_CLK_NS)
`define CDPM_BIT_HALF_CYC ((`CDPM_BIT_MIN_CYC + 1) / 2)
`define CDPM_CELL_MIN_NS 40
`define CDPM_HIZ_MAX_NS 50
`define CDPM_HIZ_MAX_CYC (`CDPM_HIZ_MAX_NS / `CDPM_CLK_NS)

`endif

// [hw/cdpm_pkg.sv]
// Types shared by the customer data port mux
package cdpm_pkg;

    // Port format chosen by software
    typedef enum logic [1:0] {
        CDPM_SERIAL = 2'h0,
        CDPM_CELL_L1 = 2'h1,
        CDPM_CELL_L2 = 2'h2
    } cdpm_mode_t;

    // Serial frame format
    typedef enum logic [1:0] {
        CDPM_FMT_E1 = 2'h0,
        CDPM_FMT_T1 = 2'h1,
        CDPM_FMT_NX64 = 2'h2
    } cdpm_fmt_t;

    // Product variant of the serial port
    typedef enum logic [1:0] {
        CDPM_VAR_SYM = 2'h0,
        CDPM_VAR_T1 = 2'h1,
        CDPM_VAR_CAP = 2'h2
    } cdpm_var_t;

    // Per-channel serial state
    typedef struct packed {
        logic [8:0] tx_pos;
        logic [8:0] rx_pos;
        logic tx_bit;
        logic rx_bit;
        logic rx_sof;
    } cdpm_chan_t;

    // Registered pin drive: shared pins plus five side pins
    typedef struct packed {
        logic [15:0] port_out;
        logic [15:0] port_oe_n;
        logic [4:0] side_out;
        logic [4:0] side_oe_n;
    } cdpm_pins_t;

endpackage : cdpm_pkg

// [hw/cdpm_sync.sv]
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module cdpm_sync #(
    parameter int W = 1
) (
    // System
    input wire logic clock,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // First stage, read only by the second
    logic [W-1:0] stage1;

    // Two registers in series
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : cdpm_sync

`default_nettype wire

// [hw/cdpm_port_mux.sv]
// Customer data port: shared pins as cell port or two-channel serial port
`timescale 1ns/1ps
`default_nettype none
`include "cdpm_map.svh"

module cdpm_port_mux
    import cdpm_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Power reset pin
    input wire logic power_reset_n,
    // Shared data pins 0 to 15
    input wire logic [15:0] shared_port_in,
    output logic [15:0] shared_port_out,
    output logic [15:0] shared_port_oe_n,
    // Cell transmit clock pin, serial channel A transmit bit clock
    input wire logic tx_clock_pin_in,
    output logic tx_clock_pin_out,
    output logic tx_clock_pin_oe_n,
    // Cell receive clock pin, serial channel A receive bit clock
    input wire logic rx_clock_pin_in,
    output logic rx_clock_pin_out,
    output logic rx_clock_pin_oe_n,
    // Start of cell in, channel A transmit frame start
    input wire logic tx_start_pin,
    // Transmit enable (low) in, channel B transmit frame start
    input wire logic tx_enable_pin,
    // Receive enable (low) in
    input wire logic rx_enable_n,
    // PHY address inputs
    input wire logic [4:0] tx_phy_addr,
    input wire logic [4:0] rx_phy_addr,
    // Receive start of cell out, channel A receive frame start
    output logic rx_start_pin_out,
    output logic rx_start_pin_oe_n,
    // Receive cell available out, channel B receive frame start
    output logic rx_clav_pin_out,
    output logic rx_clav_pin_oe_n,
    // Transmit cell available out
    output logic tx_clav_pin_out,
    output logic tx_clav_pin_oe_n
);

    // Synchronised pin inputs
    logic [23:0] s;
    // Previous clock levels: tx clock, rx clock, pin 2
    logic [2:0] clk_prev;
    // Configuration and Nx64 slot count
    logic [`CDPM_CFG_W-1:0] cfg, next_cfg;
    logic [4:0] nx64, next_nx64;
    logic [31:0] next_rdata;
    // Decoded configuration
    cdpm_mode_t mode;
    cdpm_fmt_t fmt;
    cdpm_var_t variant;
    logic byp, chb_en, pr, framed;
    logic [8:0] frame_len;
    // Bit clock divider
    logic [3:0] div_cnt, next_div_cnt;
    logic gen_clk, next_gen_clk, gen_rise, gen_fall;
    // Serial channels
    cdpm_chan_t chan [0:1];
    // Cell buffer and its state
    logic [7:0] cell_mem [0:52];
    logic [5:0] tidx, next_tidx, ridx, next_ridx;
    logic full, next_full, rx_soc, next_rx_soc;
    logic [7:0] rx_byte, next_rx_byte, cell_cnt, next_cell_cnt;
    logic tx_sel, rx_sel, tx_rise, rx_rise, tx_take, rx_take, mem_we;
    logic [5:0] mem_wi;
    // Pin drive
    cdpm_pins_t pins, next_pins;
    // Serial names on the shared pins
    logic serial_tx_data_chan_a, serial_tx_data_chan_b;
    logic serial_tx_bitclk_chan_a, serial_tx_bitclk_chan_b;
    logic tx_frame_start_chan_a, tx_frame_start_chan_b;

    // Pin inputs cross into the clock domain
    cdpm_sync #(.W(24)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({power_reset_n, rx_phy_addr, tx_phy_addr, rx_enable_n, tx_enable_pin,
                   tx_start_pin, rx_clock_pin_in, tx_clock_pin_in, shared_port_in[7:0]}),
        .sync_out(s)
    );

    // serial inputs on shared pins 0, 1, 2 and on the tx clock, start and enable pins
    assign serial_tx_data_chan_a = s[0];
    assign serial_tx_data_chan_b = s[1];
    assign serial_tx_bitclk_chan_b = s[2];
    assign serial_tx_bitclk_chan_a = s[8];
    assign tx_frame_start_chan_a = s[10];
    assign tx_frame_start_chan_b = s[11];

    // Register writes and read data
    always_comb begin
        next_cfg = cfg;
        next_nx64 = nx64;
        next_rdata = 32'h00000000;
        if (reg_write && reg_addr == `CDPM_REG_CFG) begin
            next_cfg = reg_wdata[`CDPM_CFG_W-1:0];
        end
        if (reg_write && reg_addr == `CDPM_REG_NX64) begin
            next_nx64 = reg_wdata[4:0];
        end
        if (reg_read) begin
            case (reg_addr)
                `CDPM_REG_CFG: next_rdata = {14'h0000, cfg};
                `CDPM_REG_NX64: next_rdata = {27'h0000000, nx64};
                `CDPM_REG_STATUS: next_rdata = {16'h0000, cell_cnt, 4'h0, pr, chb_en, !full, full};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // Register state
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cfg <= `CDPM_CFG_RESET;
            nx64 <= `CDPM_NX64_RESET;
            reg_rdata <= 32'h00000000;
        end else begin
            cfg <= next_cfg;
            nx64 <= next_nx64;
            reg_rdata <= next_rdata;
        end
    end

    // Decode mode and variant limits
    always_comb begin
        mode = cdpm_mode_t'(cfg[`CDPM_CFG_MODE]);
        byp = cfg[`CDPM_CFG_BYPASS];
        variant = cdpm_var_t'(cfg[`CDPM_CFG_VARIANT]);
        fmt = cdpm_fmt_t'(cfg[`CDPM_CFG_FMT]);
        pr = !s[23];
        if (variant == CDPM_VAR_T1) begin
            fmt = CDPM_FMT_T1;
        end
        framed = !byp;
        case (mode)
            // one channel on L1, both on L2
            CDPM_CELL_L1: chb_en = 1'b0;
            CDPM_CELL_L2: chb_en = 1'b1;
            CDPM_SERIAL: chb_en = cfg[`CDPM_CFG_DUAL]
                && (variant == CDPM_VAR_SYM || (variant == CDPM_VAR_CAP && byp));
            default: chb_en = 1'b0;
        endcase
        case (fmt)
            CDPM_FMT_E1: frame_len = `CDPM_E1_BITS;
            CDPM_FMT_T1: frame_len = `CDPM_T1_BITS;
            default: frame_len = (nx64 == 5'h00) ? 9'h008 : {1'b0, nx64, 3'h0};
        endcase
    end

    // divider keeps generated bit clock at least 50 ns
    always_comb begin
        next_div_cnt = div_cnt + 4'h1;
        next_gen_clk = gen_clk;
        if (div_cnt == 4'(`CDPM_BIT_HALF_CYC - 1)) begin
            next_div_cnt = 4'h0;
            next_gen_clk = !gen_clk;
        end
        gen_rise = next_gen_clk && !gen_clk;
        gen_fall = !next_gen_clk && gen_clk;
    end

    // Divider and clock-edge history
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_cnt <= 4'h0;
            gen_clk <= 1'b0;
            clk_prev <= 3'h0;
        end else begin
            div_cnt <= next_div_cnt;
            gen_clk <= next_gen_clk;
            clk_prev <= {s[2], s[9], s[8]};
        end
    end

    // Serial channels A and B
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            logic tclk, tdat, tsof, tfall, en;
            cdpm_chan_t nx;
            always_comb begin
                tclk = (gi == 0) ? serial_tx_bitclk_chan_a : serial_tx_bitclk_chan_b;
                tdat = (gi == 0) ? serial_tx_data_chan_a : serial_tx_data_chan_b;
                tsof = (gi == 0) ? tx_frame_start_chan_a : tx_frame_start_chan_b;
                en = mode == CDPM_SERIAL && !pr && (gi == 0 || chb_en);
                // framed samples far clock fall, bypass own
                tfall = byp ? gen_fall : (clk_prev[gi * 2] && !tclk);
                nx = chan[gi];
                if (en && tfall) begin
                    nx.tx_bit = tdat;
                    // frame start realigns position to bit 0
                    if (framed && tsof) begin
                        nx.tx_pos = 9'h001;
                    end else begin
                        nx.tx_pos = (chan[gi].tx_pos + 9'h001 >= frame_len) ? 9'h000
                            : chan[gi].tx_pos + 9'h001;
                    end
                end
                if (en && gen_rise) begin
                    nx.rx_bit = chan[gi].tx_bit;
                    // marker on first bit of frame
                    nx.rx_sof = framed && chan[gi].rx_pos == 9'h000;
                    nx.rx_pos = (chan[gi].rx_pos + 9'h001 >= frame_len) ? 9'h000
                        : chan[gi].rx_pos + 9'h001;
                end
            end
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    chan[gi] <= '0;
                end else begin
                    chan[gi] <= nx;
                end
            end
        end
    endgenerate

    // Cell transfers on cell-port clock rising edges
    always_comb begin
        // rising edges of the cell clocks
        tx_rise = s[8] && !clk_prev[0];
        rx_rise = s[9] && !clk_prev[1];
        tx_sel = mode == CDPM_CELL_L1 || (mode == CDPM_CELL_L2
            && (s[17:13] == cfg[`CDPM_CFG_ADDR_A] || s[17:13] == cfg[`CDPM_CFG_ADDR_B]));
        rx_sel = mode == CDPM_CELL_L1 || (mode == CDPM_CELL_L2
            && (s[22:18] == cfg[`CDPM_CFG_ADDR_A] || s[22:18] == cfg[`CDPM_CFG_ADDR_B]));
        tx_take = mode != CDPM_SERIAL && !pr && tx_rise && tx_sel && !s[11] && !full;
        rx_take = mode != CDPM_SERIAL && !pr && rx_rise && rx_sel && !s[12] && full;
        next_tidx = tidx;
        next_ridx = ridx;
        next_full = full;
        next_rx_byte = rx_byte;
        // Start of cell drops on an idle receive edge
        next_rx_soc = rx_rise ? 1'b0 : rx_soc;
        next_cell_cnt = cell_cnt;
        // start of cell opens a cell, strays dropped
        mem_we = tx_take && (s[10] || tidx != 6'h00);
        mem_wi = s[10] ? 6'h00 : tidx;
        if (mem_we) begin
            if (mem_wi == `CDPM_CELL_LAST) begin
                next_full = 1'b1;
                next_tidx = 6'h00;
            end else begin
                next_tidx = mem_wi + 6'h01;
            end
        end
        if (rx_take) begin
            next_rx_byte = cell_mem[ridx];
            next_rx_soc = ridx == 6'h00;
            if (ridx == `CDPM_CELL_LAST) begin
                next_full = 1'b0;
                next_ridx = 6'h00;
                next_cell_cnt = cell_cnt + 8'h01;
            end else begin
                next_ridx = ridx + 6'h01;
            end
        end
    end

    // Cell state registers and buffer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tidx <= 6'h00;
            ridx <= 6'h00;
            full <= 1'b0;
            rx_byte <= 8'h00;
            rx_soc <= 1'b0;
            cell_cnt <= 8'h00;
        end else begin
            tidx <= next_tidx;
            ridx <= next_ridx;
            full <= next_full;
            rx_byte <= next_rx_byte;
            rx_soc <= next_rx_soc;
            cell_cnt <= next_cell_cnt;
        end
        if (mem_we) begin
            cell_mem[mem_wi] <= s[7:0];
        end
    end

    // Pin roles per mode; enable low means driven
    always_comb begin
        next_pins = '0;
        next_pins.port_oe_n = 16'hFFFF;
        next_pins.side_oe_n = 5'h1F;
        // power reset leaves every pin floating
        if (!pr && mode == CDPM_SERIAL) begin
            // serial roles of pins 8, 9, 10 and 2
            next_pins.port_out[8] = chan[0].rx_bit;
            next_pins.port_oe_n[8] = 1'b0;
            next_pins.side_out[`CDPM_SIDE_RXCK] = gen_clk;
            next_pins.side_oe_n[`CDPM_SIDE_RXCK] = 1'b0;
            if (chb_en) begin
                next_pins.port_out[9] = chan[1].rx_bit;
                next_pins.port_oe_n[9] = 1'b0;
                next_pins.port_out[10] = gen_clk;
                next_pins.port_oe_n[10] = 1'b0;
            end
            if (byp) begin
                // bypass drives the transmit bit clocks
                next_pins.side_out[`CDPM_SIDE_TXCK] = gen_clk;
                next_pins.side_oe_n[`CDPM_SIDE_TXCK] = 1'b0;
                next_pins.port_out[2] = gen_clk;
                next_pins.port_oe_n[2] = !chb_en;
            end else begin
                // receive frame starts only when framed
                next_pins.side_out[`CDPM_SIDE_RXSTART] = chan[0].rx_sof;
                next_pins.side_oe_n[`CDPM_SIDE_RXSTART] = 1'b0;
                next_pins.side_out[`CDPM_SIDE_RXCLAV] = chan[1].rx_sof;
                next_pins.side_oe_n[`CDPM_SIDE_RXCLAV] = !chb_en;
            end
        end else if (!pr) begin
            // cell roles: pins 8 to 15 carry receive bytes
            next_pins.port_out[15:8] = rx_byte;
            next_pins.port_oe_n[15:8] = 8'h00;
            next_pins.side_out[`CDPM_SIDE_RXSTART] = rx_soc;
            next_pins.side_oe_n[`CDPM_SIDE_RXSTART] = 1'b0;
            next_pins.side_out[`CDPM_SIDE_TXCLAV] = !full;
            next_pins.side_oe_n[`CDPM_SIDE_TXCLAV] = !tx_sel;
            next_pins.side_out[`CDPM_SIDE_RXCLAV] = full;
            next_pins.side_oe_n[`CDPM_SIDE_RXCLAV] = !rx_sel;
        end
    end

    // Pin drive registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pins <= {16'h0000, 16'hFFFF, 5'h00, 5'h1F};
        end else begin
            pins <= next_pins;
        end
    end

    assign shared_port_out = pins.port_out;
    assign shared_port_oe_n = pins.port_oe_n;
    assign tx_clock_pin_out = pins.side_out[`CDPM_SIDE_TXCK];
    assign tx_clock_pin_oe_n = pins.side_oe_n[`CDPM_SIDE_TXCK];
    assign rx_clock_pin_out = pins.side_out[`CDPM_SIDE_RXCK];
    assign rx_clock_pin_oe_n = pins.side_oe_n[`CDPM_SIDE_RXCK];
    assign rx_start_pin_out = pins.side_out[`CDPM_SIDE_RXSTART];
    assign rx_start_pin_oe_n = pins.side_oe_n[`CDPM_SIDE_RXSTART];
    assign rx_clav_pin_out = pins.side_out[`CDPM_SIDE_RXCLAV];
    assign rx_clav_pin_oe_n = pins.side_oe_n[`CDPM_SIDE_RXCLAV];
    assign tx_clav_pin_out = pins.side_out[`CDPM_SIDE_TXCLAV];
    assign tx_clav_pin_oe_n = pins.side_oe_n[`CDPM_SIDE_TXCLAV];

    // Cycles since the last generated rising edge, for checking
    logic [7:0] since_rise;
    // Starts saturated so the first rise after reset is not judged short
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            since_rise <= 8'hFF;
        end else if (gen_rise) begin
            since_rise <= 8'h00;
        end else if (since_rise != 8'hFF) begin
            since_rise <= since_rise + 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_hiz_on_power: assert property ($fell(power_reset_n) |-> ##[1:12]
        (&pins.port_oe_n && &pins.side_oe_n)) else $error("outputs not floated after power reset");
    a_l1_one_chan: assert property (mode == CDPM_CELL_L1 |-> !chb_en)
        else $error("channel B enabled on L1");
    a_l2_both_chan: assert property (mode == CDPM_CELL_L2 |-> chb_en)
        else $error("channel B missing on L2");
    a_cell_pin_dirs: assert property ((mode != CDPM_SERIAL && !pr) |=>
        (pins.port_oe_n[15:8] == 8'h00 && &pins.port_oe_n[7:0])) else $error("cell pin roles wrong");
    a_l2_clav_float: assert property ((mode == CDPM_CELL_L2 && !pr && !tx_sel) |=>
        pins.side_oe_n[`CDPM_SIDE_TXCLAV]) else $error("tx cell available driven unaddressed");
    a_txclk_direction: assert property ((mode == CDPM_SERIAL && !pr) |=>
        (pins.side_oe_n[`CDPM_SIDE_TXCK] == !$past(byp))) else $error("tx bit clock direction wrong");
    a_rxclk_driven: assert property ((mode == CDPM_SERIAL && !pr) |=>
        !pins.side_oe_n[`CDPM_SIDE_RXCK]) else $error("rx bit clock not driven");
    a_sof_bypass_off: assert property ((mode == CDPM_SERIAL && byp) |=>
        pins.side_oe_n[`CDPM_SIDE_RXSTART]) else $error("frame start driven in bypass");
    a_sof_at_bit0: assert property ((mode == CDPM_SERIAL && !pr && framed && gen_rise
        && chan[0].rx_pos == 9'h000) |=> chan[0].rx_sof) else $error("frame start misplaced");
    a_bitclk_period: assert property (gen_rise |-> since_rise >= 8'(`CDPM_BIT_MIN_CYC - 1))
        else $error("serial bit clock too fast");
    a_cell_53_bytes: assert property ($rose(full) |-> $past(mem_wi) == `CDPM_CELL_LAST)
        else $error("cell closed at wrong length");
    a_clav_tracks: assert property ((mode == CDPM_CELL_L1 && !pr) |=>
        (pins.side_out[`CDPM_SIDE_RXCLAV] == $past(full)
        && pins.side_out[`CDPM_SIDE_TXCLAV] == !$past(full))) else $error("cell available wrong");
    a_t1_variant: assert property (variant == CDPM_VAR_T1 |->
        (fmt == CDPM_FMT_T1 && (mode != CDPM_SERIAL || !chb_en))) else $error("T1 variant not fixed");

    c_cell_done: cover property ($fell(full));
    c_serial_sof: cover property (chan[0].rx_sof && framed);
    c_power_float: cover property ($fell(power_reset_n));

endmodule : cdpm_port_mux

`default_nettype wire

// [tb/cdpm_atm_model.sv]
// Far-side cell port model: ATM layer device with its own byte clocks
`timescale 1ns/1ps
`default_nettype none

module cdpm_atm_model (
    // Clock pins toward the device
    output logic tx_clk,
    output logic rx_clk,
    // Transmit byte lane and controls
    output logic [7:0] tx_byte,
    output logic tx_soc,
    output logic tx_en_n,
    output logic rx_en_n,
    // Receive lane from the device
    input wire logic [7:0] rx_byte,
    input wire logic rx_soc
);
    // Clocks stand still between transfers
    initial begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        tx_byte = 8'hA5;
        tx_soc = 1'b0;
        tx_en_n = 1'b1;
        rx_en_n = 1'b1;
    end

    // byte offered across one 80 ns cycle, rising edge at 40 ns
    task automatic put_byte(input logic [7:0] b, input logic soc);
        tx_byte = b;
        tx_soc = soc;
        tx_en_n = 1'b0;
        #40 tx_clk = 1'b1;
        // falling edge at 60 ns, lane held 10 ns past it for serial sampling
        #20 tx_clk = 1'b0;
        // Released lane shows the inverse, never a stale byte
        #10 tx_byte = ~b;
        tx_soc = 1'b0;
        tx_en_n = 1'b1;
        // Idle gap so a following call never rewrites a signal in one step
        #10;
    endtask : put_byte

    // one receive byte, sampled once the device output settled
    task automatic get_byte(output logic [7:0] b, output logic soc);
        rx_en_n = 1'b0;
        #40 rx_clk = 1'b1;
        // Device output settles well within 30 ns of the rising edge
        #30 b = rx_byte;
        soc = rx_soc;
        rx_clk = 1'b0;
        rx_en_n = 1'b1;
        // Idle gap before the next byte
        #10;
    endtask : get_byte
endmodule : cdpm_atm_model

`default_nettype wire

// [tb/cdpm_port_mux_test.sv]
// Self-checking bench of the customer data port mux
`timescale 1ns/1ps
`default_nettype none
`include "cdpm_map.svh"

module cdpm_port_mux_test;
    import cdpm_pkg::*;
    // Stimulus and observed pins
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic power_reset_n = 1'b1;
    logic [4:0] phy_addr = 5'h00;
    logic [31:0] reg_rdata;
    logic [15:0] port_out, port_oe_n;
    logic txc_out, txc_oe_n, rxc_out, rxc_oe_n, rxs_out, rxs_oe_n;
    logic rclav, rclav_oe_n, tclav, tclav_oe_n;
    logic tx_clk, rx_clk, tx_soc, tx_en_n, rx_en_n;
    logic [7:0] tx_byte;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    wire [20:0] oe_all = {port_oe_n, txc_oe_n, rxc_oe_n, rxs_oe_n, rclav_oe_n, tclav_oe_n};

    // Clock of 4 ns
    always #2 clock = ~clock;

    cdpm_port_mux dut_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .power_reset_n(power_reset_n),
        .shared_port_in({8'h00, tx_byte}), .shared_port_out(port_out),
        .shared_port_oe_n(port_oe_n), .tx_clock_pin_in(tx_clk), .tx_clock_pin_out(txc_out),
        .tx_clock_pin_oe_n(txc_oe_n), .rx_clock_pin_in(rx_clk), .rx_clock_pin_out(rxc_out),
        .rx_clock_pin_oe_n(rxc_oe_n), .tx_start_pin(tx_soc), .tx_enable_pin(tx_en_n),
        .rx_enable_n(rx_en_n), .tx_phy_addr(phy_addr), .rx_phy_addr(phy_addr),
        .rx_start_pin_out(rxs_out), .rx_start_pin_oe_n(rxs_oe_n),
        .rx_clav_pin_out(rclav), .rx_clav_pin_oe_n(rclav_oe_n),
        .tx_clav_pin_out(tclav), .tx_clav_pin_oe_n(tclav_oe_n));

    cdpm_atm_model partner_u (.tx_clk(tx_clk), .rx_clk(rx_clk), .tx_byte(tx_byte),
        .tx_soc(tx_soc), .tx_en_n(tx_en_n), .rx_en_n(rx_en_n),
        .rx_byte(port_out[15:8]), .rx_soc(rxs_out));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Register write and read, one-cycle strobes
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd_chk

    // Reset values, field widths, unmapped place
    task automatic test_regs();
        rd_chk(`CDPM_REG_CFG, 32'h0);
        rd_chk(`CDPM_REG_NX64, 32'h1);
        wr(`CDPM_REG_NX64, 32'hFFFFFFFF);
        rd_chk(`CDPM_REG_NX64, 32'h1F);
        wr(4'hC, 32'hFFFFFFFF);
        rd_chk(4'hC, 32'h0);
    endtask : test_regs

    // Serial pin directions, bit clocks, framed loopback and variant limits
    task automatic test_serial();
        int n;
        int m;
        logic last;
        logic last_tx;
        wr(`CDPM_REG_CFG, 32'h4);
        repeat (6) @(posedge clock);
        chk({txc_oe_n, rxc_oe_n, port_oe_n[8], port_oe_n[0]}, 4'h1);
        #1 n = 0;
        m = 0;
        last = rxc_out;
        last_tx = txc_out;
        repeat (28) begin
            @(posedge clock);
            #1 n += (rxc_out !== last);
            m += (txc_out !== last_tx);
            last = rxc_out;
            last_tx = txc_out;
        end
        chk(n, 4);
        chk(m, 4);
        wr(`CDPM_REG_CFG, 32'h0);
        repeat (6) @(posedge clock);
        chk({txc_oe_n, rxc_oe_n, port_oe_n[8], port_oe_n[0], rxs_oe_n}, 5'h12);
        // Far clock frames bits; zeros then ones loop back to pin 8
        partner_u.put_byte(8'h00, 1'b1);
        repeat (8) partner_u.put_byte(8'h00, 1'b0);
        repeat (20) @(posedge clock);
        #1 chk(port_out[8], 1'b0);
        repeat (3) partner_u.put_byte(8'hFF, 1'b0);
        repeat (20) @(posedge clock);
        #1 chk(port_out[8], 1'b1);
        wr(`CDPM_REG_CFG, 32'h80);
        rd_chk(`CDPM_REG_STATUS, 32'h6);
        wr(`CDPM_REG_CFG, 32'hA0);
        rd_chk(`CDPM_REG_STATUS, 32'h2);
        wr(`CDPM_REG_CFG, 32'hC0);
        rd_chk(`CDPM_REG_STATUS, 32'h2);
        wr(`CDPM_REG_CFG, 32'hC4);
        rd_chk(`CDPM_REG_STATUS, 32'h6);
    endtask : test_serial

    // Level 2 addressing gates the cell-available pins
    task automatic test_level2();
        wr(`CDPM_REG_CFG, 32'hA302);
        repeat (6) @(posedge clock);
        chk({tclav_oe_n, rclav_oe_n}, 2'b11);
        rd_chk(`CDPM_REG_STATUS, 32'h6);
        @(posedge clock);
        phy_addr <= 5'h05;
        repeat (6) @(posedge clock);
        chk({tclav_oe_n, rclav_oe_n}, 2'b00);
        phy_addr <= 5'h1F;
    endtask : test_level2

    // Level 1 cell through the one-cell loopback buffer
    task automatic test_cell();
        logic [7:0] b;
        logic s;
        wr(`CDPM_REG_CFG, 32'h1);
        repeat (6) @(posedge clock);
        chk(port_oe_n, 16'h00FF);
        chk({tclav_oe_n, rclav_oe_n}, 2'b00);
        partner_u.put_byte(8'hEE, 1'b0);
        for (int i = 0; i < 53; i++) partner_u.put_byte(8'h40 + i[7:0], i == 0);
        repeat (8) @(posedge clock);
        chk({tclav, rclav}, 2'b01);
        for (int i = 0; i < 53; i++) begin
            partner_u.get_byte(b, s);
            chk({s, b}, {i == 0, 8'h40 + i[7:0]});
        end
        repeat (8) @(posedge clock);
        chk({tclav, rclav}, 2'b10);
        rd_chk(`CDPM_REG_STATUS, 32'h0102);
    endtask : test_cell

    // Power reset floats every output
    task automatic test_power();
        power_reset_n <= 1'b0;
        repeat (12) @(posedge clock);
        #1 chk(oe_all, 21'h1FFFFF);
        power_reset_n <= 1'b1;
    endtask : test_power

    // Verdict and end of run
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        #1 chk(oe_all, 21'h1FFFFF);
        test_regs();
        test_serial();
        test_level2();
        test_cell();
        test_power();
        end_of_test();
    end
endmodule : cdpm_port_mux_test

`default_nettype wire
